// ### ddc_chk_sva.sv
// Assertions on the object channel between the master and drive ends.
// Takes the interface signals as plain inputs; placed beside the interface.
`timescale 1ns/1ps
`default_nettype none
module ddc_chk_sva
	import ddc_pkg::*;
(
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        arst_n,
	// Object channel
	input wire logic        req,
	input wire logic        wr,
	input wire logic [15:0] idx,
	input wire logic [15:0] wdata,
	input wire logic        ack,
	input wire logic        abort,
	input wire logic [15:0] rdata
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	// Handshake timing: one answer per request, exactly one cycle late
	a_ack_after_req: assert property ($rose(req) |=> ack)
		else $error("no ack one cycle after request");
	a_ack_one_pulse: assert property (ack |=> !ack)
		else $error("ack longer than one cycle");
	a_req_held_steady: assert property (req && !ack |=> req && $stable(idx) && $stable(wr))
		else $error("request changed before ack");
	a_req_dropped: assert property (ack |=> !req)
		else $error("request kept after ack");
	a_abort_with_ack: assert property (abort |-> ack)
		else $error("abort without ack");
	// Access kinds of the objects
	a_cmd_word_rw: assert property (ack && idx == IDX_CMD_WORD |-> !abort)
		else $error("command word access refused");
	a_state_word_ro: assert property (ack && wr && idx == IDX_STATE_WORD |-> abort)
		else $error("state word write accepted");
	a_no_remote_bit: assert property (ack && !wr && idx == IDX_STATE_WORD |-> !rdata[9])
		else $error("remote bit set in state word");
	a_mode_sel_wo: assert property (ack && !wr && idx == IDX_MODE_SEL |-> abort)
		else $error("mode selection read accepted");
	// Option ranges decide the refusal exactly
	a_qs_opt_range: assert property (ack && wr && idx == IDX_QS_OPT |-> abort ==
		($signed(wdata) < QS_MIN || $signed(wdata) > QS_MAX))
		else $error("quick-stop option range wrong");
	a_sd_opt_range: assert property (ack && wr && idx == IDX_SD_OPT |-> abort ==
		($signed(wdata) < SD_MIN || $signed(wdata) > SD_MAX))
		else $error("shutdown option range wrong");
	a_halt_opt_range: assert property (ack && wr && idx == IDX_HALT_OPT |-> abort ==
		($signed(wdata) < HF_MIN || $signed(wdata) > HF_MAX))
		else $error("halt option range wrong");
endmodule
`default_nettype wire

// ### ddc_drive.sv
// Drive-side device control: object registers, command decode, power
// state machine and stop-reaction selection for the motion logic.
// Assumes the motion logic reports ramp completion on stop_done.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1: Decode shutdown, switch-on, disable-voltage, quick-stop from bits
// R2: 0111 disables, 1111 enables; bit7 rise resets fault
// R3: Command word is read/write at its index
// R4: State word read-only, always shows current state
// R5: Internal error runs fault reaction, then fault
// R6: Positioning starts only when operation enabled
// R7: Initialising: not ready, drive off, brake on
// R8: Switch-on disabled holds while safety inputs inactive
// R9: Ready and switched-on: power on, drive off
// R10: Operation enabled only without error; drive on
// R11: Quick-stop option 0..8 selects stop kind
// R12: Stay variants hold quick stop until enable
// R13: Shutdown option -1..1 selects shutdown reaction
// R14: Disable-operation option 0..1 selects reaction
// R15: Halt option 0..4 selects halt reaction
// R16: Fault-reaction option 0..4, same meanings as halt
// R17: Quick-stop ramp uses profile smoothing
// R18: Error-stop ramp never uses smoothing
// R19: Mode codes 1,3,6,7 and cyclic 8..10
// R20: Master commands only over the object channel
// R21: No remote indication in the state word
// R22: Mode display mirrors selected mode encoding
// R23: Profile state encoding; invalid commands ignored
module ddc_drive
	import ddc_pkg::*;
#(
	parameter bit CYCLIC_MODES = 1'b1
) (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       arst_n,
	// Object channel
	ddc_if.drive            bus,
	// Pins and internal events
	input  wire logic       safe_torque_off_input,
	input  wire logic       power_stage_enable_input,
	input  wire logic       init_done,
	input  wire logic       fault_event,
	input  wire logic       stop_done,
	input  wire logic       pp_start_req,
	// Drive control outputs
	output logic            pp_start_grant,
	output logic            drive_enable,
	output logic            brake_engage,
	output logic            power_applied,
	output logic            amp_ready,
	output logic            stop_active,
	output ddc_stop_t       stop_kind,
	output logic            stop_smooth,
	output logic            halt_active,
	output ddc_stop_t       halt_kind,
	output logic [7:0]      mode_active,
	output ddc_state_t      drive_state
);

	ddc_state_t  state_r, state_nxt, tgt_r, tgt_nxt;
	ddc_stop_t   kind_r, kind_nxt;
	logic        stopping_r, stopping_nxt;
	logic [15:0] cw_r, qs_r, sd_r, do_r, halt_r, fr_r;
	logic [7:0]  mode_r;
	logic        fr_prev_r, ack_r, abort_r;
	logic [15:0] rdata_r, rd_nxt, state_word;
	logic        bad;
	logic [1:0]  pin_s1_r, pin_s2_r;

	// Option value to stop kind; quick-stop stay variants fold onto 1..4
	function automatic ddc_stop_t opt_kind(input logic [15:0] v);
		logic [15:0] w;
		w = ($signed(v) >= QS_STAY_MIN) ? v - 16'h0004 : v;
		unique case (w[2:0])
			3'h1:    opt_kind = STOP_SLOW_RAMP;
			3'h2:    opt_kind = STOP_QS_RAMP;
			3'h3:    opt_kind = STOP_CUR_LIM;
			3'h4:    opt_kind = STOP_VOLT_LIM;
			default: opt_kind = STOP_COAST;
		endcase
	endfunction

	// Safety pins come from outside, so two flops before any use
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_s1_r <= 2'h0;
			pin_s2_r <= 2'h0;
		end else begin
			pin_s1_r <= {safe_torque_off_input, power_stage_enable_input};
			pin_s2_r <= pin_s1_r;
		end
	end

	// Command decode from the stored command word
	wire       hw_ok     = &pin_s2_r;
	wire [3:0] cw_cmd    = cw_r[CW_EO:CW_SO];
	wire       b7_low    = ~cw_r[CW_FR];
	wire       c_shut    = b7_low && cw_cmd[2:0] == 3'b110;                  // [R1]
	wire       c_son     = b7_low && cw_cmd[2:0] == 3'b111;                  // [R1]
	wire       c_dvolt   = b7_low && !cw_r[CW_EV] && cw_r[CW_SO];            // [R1]
	wire       c_qstop   = b7_low && !cw_r[CW_QS] && cw_r[CW_EV];            // [R1]
	wire       c_dis_op  = b7_low && cw_cmd == 4'b0111;                      // [R2]
	wire       c_en_op   = b7_low && cw_cmd == 4'b1111;                      // [R2]
	wire       c_frst    = cw_r[CW_FR] && !fr_prev_r;                        // [R2]
	wire       qs_stay   = $signed(qs_r) >= QS_STAY_MIN;                     // [R12]
	wire       drop_pwr  = !hw_ok || c_dvolt;
	wire       ramp_over = !stopping_r || stop_done;
	wire       mode_ok   = mode_sel_ok(bus.wdata[7:0]);

	// Legal mode codes; cyclic modes only on the cyclic-capable variant
	function automatic logic mode_sel_ok(input logic [7:0] m);
		mode_sel_ok = m == MODE_PP || m == MODE_PV || m == MODE_HOM ||
			m == MODE_IP || (CYCLIC_MODES && m >= MODE_CSP && m <= MODE_CST); // [R19]
	endfunction

	// Next state; error detection overrides any command
	always_comb begin
		state_nxt    = state_r;
		tgt_nxt      = tgt_r;
		kind_nxt     = kind_r;
		stopping_nxt = stopping_r;
		if (fault_event && state_r != ST_NOT_READY && state_r != ST_FAULT_REACT &&
			state_r != ST_FAULT) begin
			state_nxt    = ST_FAULT_REACT;                                  // [R5]
			kind_nxt     = opt_kind(fr_r);                                  // [R16]
			stopping_nxt = opt_kind(fr_r) != STOP_COAST;
		end else begin
			unique case (state_r)
				ST_NOT_READY:   if (init_done) state_nxt = ST_SW_ON_DIS;     // [R7]
				ST_SW_ON_DIS:   if (hw_ok && c_shut) state_nxt = ST_READY;   // [R8]
				ST_READY: begin
					if (drop_pwr || c_qstop) state_nxt = ST_SW_ON_DIS;
					else if (c_son) state_nxt = ST_SWITCHED_ON;
				end
				ST_SWITCHED_ON: begin
					if (drop_pwr || c_qstop) state_nxt = ST_SW_ON_DIS;
					else if (c_shut) state_nxt = ST_READY;
					else if (c_en_op) state_nxt = ST_OP_EN;                  // [R10]
				end
				ST_OP_EN: begin
					if (drop_pwr) begin
						state_nxt    = ST_SW_ON_DIS;
						stopping_nxt = 1'b0;
					end else if (stopping_r) begin
						if (stop_done) begin
							state_nxt    = tgt_r;
							stopping_nxt = 1'b0;
						end
					end else if (c_qstop) begin
						state_nxt    = ST_QSTOP;                             // [R11]
						kind_nxt     = opt_kind(qs_r);
						stopping_nxt = opt_kind(qs_r) != STOP_COAST;
					end else if (c_shut) begin
						tgt_nxt      = ST_READY;                             // [R13]
						kind_nxt     = ($signed(sd_r) < 0) ? opt_kind(qs_r) : opt_kind(sd_r);
						stopping_nxt = kind_nxt != STOP_COAST;
						if (kind_nxt == STOP_COAST) state_nxt = ST_READY;
					end else if (c_dis_op) begin
						tgt_nxt      = ST_SWITCHED_ON;                       // [R14]
						kind_nxt     = opt_kind(do_r);
						stopping_nxt = do_r[0];
						if (!do_r[0]) state_nxt = ST_SWITCHED_ON;
					end
				end
				ST_QSTOP: begin
					if (stop_done) stopping_nxt = 1'b0;
					if (drop_pwr) begin
						state_nxt    = ST_SW_ON_DIS;
						stopping_nxt = 1'b0;
					end else if (qs_stay) begin
						if (c_en_op) begin
							state_nxt    = ST_OP_EN;                     // [R12]
							stopping_nxt = 1'b0;
						end
					end else if (ramp_over) state_nxt = ST_SW_ON_DIS;
				end
				ST_FAULT_REACT: begin
					if (ramp_over) begin
						state_nxt    = ST_FAULT;                         // [R5]
						stopping_nxt = 1'b0;
					end
				end
				ST_FAULT: if (c_frst && !fault_event) state_nxt = ST_SW_ON_DIS; // [R2]
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r    <= ST_NOT_READY;
			tgt_r      <= ST_READY;
			kind_r     <= STOP_COAST;
			stopping_r <= 1'b0;
			fr_prev_r  <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			tgt_r      <= tgt_nxt;
			kind_r     <= kind_nxt;
			stopping_r <= stopping_nxt;
			fr_prev_r  <= cw_r[CW_FR];
		end
	end

	// Profile state word; remote bit 9 is never set
	always_comb begin
		unique case (state_r)
			ST_NOT_READY:   state_word = SW_NOT_READY;                   // [R23]
			ST_SW_ON_DIS:   state_word = SW_SW_ON_DIS;
			ST_READY:       state_word = SW_READY;
			ST_SWITCHED_ON: state_word = SW_SWITCHED_ON;
			ST_OP_EN:       state_word = SW_OP_EN;
			ST_QSTOP:       state_word = SW_QSTOP;
			ST_FAULT_REACT: state_word = SW_FAULT_REACT;
			ST_FAULT:       state_word = SW_FAULT;
		endcase
		if (power_applied) state_word = state_word | SW_VOLTAGE;       // [R21]
	end

	// Object decode: bad index, wrong direction or out-of-range value aborts
	always_comb begin
		rd_nxt = 16'h0000;
		bad    = 1'b0;
		case (bus.idx)
			IDX_CMD_WORD:   rd_nxt = cw_r;                               // [R3]
			IDX_STATE_WORD: begin rd_nxt = state_word; bad = bus.wr; end // [R4]
			IDX_QS_OPT: begin
				rd_nxt = qs_r;
				bad    = bus.wr && ($signed(bus.wdata) < QS_MIN || $signed(bus.wdata) > QS_MAX);
			end
			IDX_SD_OPT: begin
				rd_nxt = sd_r;
				bad    = bus.wr && ($signed(bus.wdata) < SD_MIN || $signed(bus.wdata) > SD_MAX);
			end
			IDX_DO_OPT: begin
				rd_nxt = do_r;
				bad    = bus.wr && ($signed(bus.wdata) < DO_MIN || $signed(bus.wdata) > DO_MAX);
			end
			IDX_HALT_OPT: begin
				rd_nxt = halt_r;
				bad    = bus.wr && ($signed(bus.wdata) < HF_MIN || $signed(bus.wdata) > HF_MAX);
			end
			IDX_FR_OPT: begin
				rd_nxt = fr_r;
				bad    = bus.wr && ($signed(bus.wdata) < HF_MIN || $signed(bus.wdata) > HF_MAX);
			end
			IDX_MODE_SEL:  bad = !bus.wr || bus.wdata[15:8] != 8'h00 || !mode_ok; // [R19]
			IDX_MODE_SHOW: begin rd_nxt = {8'h00, mode_r}; bad = bus.wr; end     // [R22]
			default:       bad = 1'b1;
		endcase
	end

	wire take = bus.req && !ack_r;
	wire we   = take && bus.wr && !bad;

	// Object storage and one-cycle answer
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cw_r    <= CW_RST;
			qs_r    <= QS_RST;
			sd_r    <= SD_RST;
			do_r    <= DO_RST;
			halt_r  <= HALT_RST;
			fr_r    <= FR_RST;
			mode_r  <= MODE_RST;
			ack_r   <= 1'b0;
			abort_r <= 1'b0;
			rdata_r <= 16'h0000;
		end else begin
			ack_r   <= take;
			abort_r <= take && bad;
			rdata_r <= (take && !bus.wr && !bad) ? rd_nxt : 16'h0000;
			if (we && bus.idx == IDX_CMD_WORD) cw_r <= bus.wdata;       // [R3]
			if (we && bus.idx == IDX_QS_OPT) qs_r <= bus.wdata;         // [R11]
			if (we && bus.idx == IDX_SD_OPT) sd_r <= bus.wdata;         // [R13]
			if (we && bus.idx == IDX_DO_OPT) do_r <= bus.wdata;         // [R14]
			if (we && bus.idx == IDX_HALT_OPT) halt_r <= bus.wdata;     // [R15]
			if (we && bus.idx == IDX_FR_OPT) fr_r <= bus.wdata;         // [R16]
			if (we && bus.idx == IDX_MODE_SEL) mode_r <= bus.wdata[7:0]; // [R22]
		end
	end

	assign bus.ack   = ack_r;
	assign bus.abort = abort_r;
	assign bus.rdata = rdata_r;

	// Power and drive outputs decoded from the state register
	assign drive_enable   = state_r == ST_OP_EN || state_r == ST_QSTOP ||
		state_r == ST_FAULT_REACT;                                       // [R10]
	assign brake_engage   = !drive_enable;                              // [R7]
	assign power_applied  = state_r != ST_NOT_READY && state_r != ST_SW_ON_DIS &&
		state_r != ST_FAULT;                                             // [R9]
	assign amp_ready      = power_applied && state_r != ST_READY;       // [R9]
	assign pp_start_grant = pp_start_req && state_r == ST_OP_EN && !stopping_r; // [R6]
	assign stop_active    = stopping_r;
	assign stop_kind      = kind_r;
	// Smoothing only on non-error ramps; an error stop must be as short as possible
	assign stop_smooth    = stopping_r && state_r != ST_FAULT_REACT;    // [R17] [R18]
	assign halt_active    = state_r == ST_OP_EN && !stopping_r && cw_r[CW_HALT]; // [R15]
	assign halt_kind      = opt_kind(halt_r);
	assign mode_active    = mode_r;
	assign drive_state    = state_r;

endmodule
`default_nettype wire

// ### ddc_if.sv
// Object access carrier between fieldbus master and drive control.
// Master holds req until the drive returns a one-cycle ack.
`timescale 1ns/1ps
`default_nettype none
interface ddc_if;
	logic        req;
	logic        wr;
	logic [15:0] idx;
	logic [15:0] wdata;
	logic        ack;
	logic        abort;
	logic [15:0] rdata;

	modport master (output req, output wr, output idx, output wdata,
		input ack, input abort, input rdata);
	modport drive (input req, input wr, input idx, input wdata,
		output ack, output abort, output rdata);
endinterface
`default_nettype wire

// ### ddc_master.sv
// Fieldbus master end: raw object access plus encoded drive commands.
// Assumes the drive answers every request with one ack pulse.
`timescale 1ns/1ps
`default_nettype none
module ddc_master
	import ddc_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	// Object channel
	ddc_if.master            bus,
	// Raw object access
	input  wire logic        acc_valid,
	input  wire logic        acc_write,
	input  wire logic [15:0] acc_index,
	input  wire logic [15:0] acc_data,
	// Drive command request
	input  wire logic        dcmd_valid,
	input  wire ddc_dcmd_t   dcmd,
	// Shared ready and answer
	output logic             acc_ready,
	output logic             done,
	output logic             done_abort,
	output logic [15:0]      done_data
);

	logic        busy_r, req_r, wr_r, second_r;
	logic [15:0] idx_r, dat_r, cwc;
	logic        done_r, abort_r;
	logic [15:0] rd_r;

	// Command word patterns for each drive command
	always_comb begin
		unique case (dcmd)
			DC_SHUTDOWN:    cwc = CWC_SHUTDOWN;                          // [R1]
			DC_SWITCH_ON:   cwc = CWC_SWITCH_ON;
			DC_DVOLT:       cwc = CWC_DVOLT;
			DC_QSTOP:       cwc = CWC_QSTOP;
			DC_DIS_OP:      cwc = CWC_DIS_OP;                            // [R2]
			DC_EN_OP:       cwc = CWC_EN_OP;
			DC_FAULT_RESET: cwc = CWC_FR_LOW;
			default:        cwc = CWC_FR_LOW;
		endcase
	end

	assign acc_ready = !busy_r;
	wire   start_acc = !busy_r && acc_valid;
	wire   start_cmd = !busy_r && !acc_valid && dcmd_valid;

	// All commands go over the object channel only; fault reset writes
	// bit 7 low then high so the drive always sees a rising edge
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			busy_r   <= 1'b0;
			req_r    <= 1'b0;
			wr_r     <= 1'b0;
			second_r <= 1'b0;
			idx_r    <= 16'h0000;
			dat_r    <= 16'h0000;
			done_r   <= 1'b0;
			abort_r  <= 1'b0;
			rd_r     <= 16'h0000;
		end else begin
			done_r <= 1'b0;
			if (start_acc) begin
				busy_r <= 1'b1;                                          // [R20]
				req_r  <= 1'b1;
				wr_r   <= acc_write;
				idx_r  <= acc_index;
				dat_r  <= acc_data;
			end else if (start_cmd) begin
				busy_r   <= 1'b1;
				req_r    <= 1'b1;
				wr_r     <= 1'b1;
				idx_r    <= IDX_CMD_WORD;
				dat_r    <= cwc;
				second_r <= dcmd == DC_FAULT_RESET;                      // [R2]
			end else if (req_r && bus.ack) begin
				req_r <= 1'b0;
				if (second_r && !bus.abort) begin
					second_r <= 1'b0;
					dat_r    <= CWC_FR_HIGH;
				end else begin
					busy_r   <= 1'b0;
					second_r <= 1'b0;
					done_r   <= 1'b1;
					abort_r  <= bus.abort;
					rd_r     <= bus.rdata;
				end
			end else if (busy_r && !req_r) begin
				req_r <= 1'b1;
			end
		end
	end

	assign bus.req     = req_r;
	assign bus.wr      = wr_r;
	assign bus.idx     = idx_r;
	assign bus.wdata   = dat_r;
	assign done        = done_r;
	assign done_abort  = abort_r;
	assign done_data   = rd_r;

endmodule
`default_nettype wire

// ### ddc_pkg.sv
// Package for the drive device-control state machine: object indices,
// control-word bit positions, option ranges, reset values and state types.
// Assumes a 16-bit object access port between fieldbus master and drive.
`default_nettype none
package ddc_pkg;

	// Object indices
	localparam logic [15:0] IDX_CMD_WORD   = 16'h6040;
	localparam logic [15:0] IDX_STATE_WORD = 16'h6041;
	localparam logic [15:0] IDX_QS_OPT     = 16'h605a;
	localparam logic [15:0] IDX_SD_OPT     = 16'h605b;
	localparam logic [15:0] IDX_DO_OPT     = 16'h605c;
	localparam logic [15:0] IDX_HALT_OPT   = 16'h605d;
	localparam logic [15:0] IDX_FR_OPT     = 16'h605e;
	localparam logic [15:0] IDX_MODE_SEL   = 16'h6060;
	localparam logic [15:0] IDX_MODE_SHOW  = 16'h6061;

	// Command word bit positions
	localparam int CW_SO   = 0;
	localparam int CW_EV   = 1;
	localparam int CW_QS   = 2;
	localparam int CW_EO   = 3;
	localparam int CW_FR   = 7;
	localparam int CW_HALT = 8;

	// Option ranges (signed objects)
	localparam logic signed [15:0] QS_MIN = 16'sh0000;
	localparam logic signed [15:0] QS_MAX = 16'sh0008;
	localparam logic signed [15:0] QS_STAY_MIN = 16'sh0005;
	localparam logic signed [15:0] SD_MIN = 16'shffff;
	localparam logic signed [15:0] SD_MAX = 16'sh0001;
	localparam logic signed [15:0] DO_MIN = 16'sh0000;
	localparam logic signed [15:0] DO_MAX = 16'sh0001;
	localparam logic signed [15:0] HF_MIN = 16'sh0000;
	localparam logic signed [15:0] HF_MAX = 16'sh0004;

	// Reset values
	localparam logic [15:0] CW_RST   = 16'h0000;
	localparam logic [15:0] QS_RST   = 16'h0002;
	localparam logic [15:0] SD_RST   = 16'h0000;
	localparam logic [15:0] DO_RST   = 16'h0001;
	localparam logic [15:0] HALT_RST = 16'h0001;
	localparam logic [15:0] FR_RST   = 16'h0002;
	localparam logic [7:0]  MODE_RST = 8'h00;

	// Mode codes
	localparam logic [7:0] MODE_PP  = 8'h01;
	localparam logic [7:0] MODE_PV  = 8'h03;
	localparam logic [7:0] MODE_HOM = 8'h06;
	localparam logic [7:0] MODE_IP  = 8'h07;
	localparam logic [7:0] MODE_CSP = 8'h08;
	localparam logic [7:0] MODE_CST = 8'h0a;

	// State word per state; voltage bit added while power is applied
	localparam logic [15:0] SW_NOT_READY   = 16'h0000;
	localparam logic [15:0] SW_SW_ON_DIS   = 16'h0040;
	localparam logic [15:0] SW_READY       = 16'h0021;
	localparam logic [15:0] SW_SWITCHED_ON = 16'h0023;
	localparam logic [15:0] SW_OP_EN       = 16'h0027;
	localparam logic [15:0] SW_QSTOP       = 16'h0007;
	localparam logic [15:0] SW_FAULT_REACT = 16'h000f;
	localparam logic [15:0] SW_FAULT       = 16'h0008;
	localparam logic [15:0] SW_VOLTAGE     = 16'h0010;

	// Command words the master sends
	localparam logic [15:0] CWC_SHUTDOWN  = 16'h0006;
	localparam logic [15:0] CWC_SWITCH_ON = 16'h0007;
	localparam logic [15:0] CWC_DVOLT     = 16'h0001;
	localparam logic [15:0] CWC_QSTOP     = 16'h0002;
	localparam logic [15:0] CWC_DIS_OP    = 16'h0007;
	localparam logic [15:0] CWC_EN_OP     = 16'h000f;
	localparam logic [15:0] CWC_FR_LOW    = 16'h0000;
	localparam logic [15:0] CWC_FR_HIGH   = 16'h0080;

	typedef enum logic [2:0] {
		ST_NOT_READY, ST_SW_ON_DIS, ST_READY, ST_SWITCHED_ON,
		ST_OP_EN, ST_QSTOP, ST_FAULT_REACT, ST_FAULT
	} ddc_state_t;

	typedef enum logic [2:0] {
		STOP_COAST, STOP_SLOW_RAMP, STOP_QS_RAMP, STOP_CUR_LIM, STOP_VOLT_LIM
	} ddc_stop_t;

	typedef enum logic [2:0] {
		DC_SHUTDOWN, DC_SWITCH_ON, DC_DVOLT, DC_QSTOP,
		DC_DIS_OP, DC_EN_OP, DC_FAULT_RESET
	} ddc_dcmd_t;

endpackage
`default_nettype wire

// ### test_drive_device_control_fsm.sv
// Testbench: master and drive ends joined by the object channel.
// Drives the master user side and the drive pins; watches both ends.
`timescale 1ns/1ps
`default_nettype none
module test_drive_device_control_fsm;
	import ddc_pkg::*;
	typedef struct packed {
		logic w; logic [15:0] i; logic [15:0] d; logic ab; logic [15:0] rd;
	} ddc_row_t;

	logic        sys_clk = 1'b0;
	logic        arst_n;
	logic        acc_valid, acc_write, dcmd_valid, acc_ready, done, done_abort;
	logic [15:0] acc_index, acc_data, done_data;
	ddc_dcmd_t   dcmd;
	logic        safe_torque_off_input, power_stage_enable_input, init_done;
	logic        fault_event, stop_done, pp_start_req, pp_start_grant;
	logic        drive_enable, brake_engage, power_applied, amp_ready;
	logic        stop_active, stop_smooth, halt_active;
	ddc_stop_t   stop_kind, halt_kind;
	logic [7:0]  mode_active;
	ddc_state_t  drive_state;
	int          n_errors = 0;
	int          n_checks = 0;
	logic [7:0]  modes [7] = '{8'h01, 8'h03, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a};
	// Reads show reset values and written values; writes probe range and access refusals
	ddc_row_t    rows [24] = '{
		'{1'b0,16'h6040,16'h0000,1'b0,16'h0000}, '{1'b0,16'h6041,16'h0000,1'b0,16'h0000},
		'{1'b0,16'h605a,16'h0000,1'b0,16'h0002}, '{1'b0,16'h605b,16'h0000,1'b0,16'h0000},
		'{1'b0,16'h605c,16'h0000,1'b0,16'h0001}, '{1'b0,16'h605d,16'h0000,1'b0,16'h0001},
		'{1'b0,16'h605e,16'h0000,1'b0,16'h0002}, '{1'b1,16'h605a,16'h0009,1'b1,16'h0000},
		'{1'b1,16'h605a,16'h0006,1'b0,16'h0000}, '{1'b0,16'h605a,16'h0000,1'b0,16'h0006},
		'{1'b1,16'h605b,16'hffff,1'b0,16'h0000}, '{1'b1,16'h605b,16'h0002,1'b1,16'h0000},
		'{1'b1,16'h605c,16'h0002,1'b1,16'h0000}, '{1'b1,16'h605d,16'h0005,1'b1,16'h0000},
		'{1'b1,16'h605e,16'hffff,1'b1,16'h0000}, '{1'b1,16'h605e,16'h0004,1'b0,16'h0000},
		'{1'b1,16'h6041,16'h0001,1'b1,16'h0000}, '{1'b0,16'h6060,16'h0000,1'b1,16'h0000},
		'{1'b1,16'h6060,16'h0101,1'b1,16'h0000}, '{1'b1,16'h6060,16'h0002,1'b1,16'h0000},
		'{1'b1,16'h6040,16'h1234,1'b0,16'h0000}, '{1'b0,16'h6040,16'h0000,1'b0,16'h1234},
		'{1'b1,16'h6040,16'h0000,1'b0,16'h0000}, '{1'b0,16'h6042,16'h0000,1'b1,16'h0000}};

	ddc_if u_ddc_if ();
	ddc_master u_ddc_master (.sys_clk(sys_clk), .arst_n(arst_n), .bus(u_ddc_if),
		.acc_valid(acc_valid), .acc_write(acc_write), .acc_index(acc_index),
		.acc_data(acc_data), .dcmd_valid(dcmd_valid), .dcmd(dcmd), .acc_ready(acc_ready),
		.done(done), .done_abort(done_abort), .done_data(done_data));
	ddc_drive u_ddc_drive (.sys_clk(sys_clk), .arst_n(arst_n), .bus(u_ddc_if),
		.safe_torque_off_input(safe_torque_off_input),
		.power_stage_enable_input(power_stage_enable_input), .init_done(init_done),
		.fault_event(fault_event), .stop_done(stop_done), .pp_start_req(pp_start_req),
		.pp_start_grant(pp_start_grant), .drive_enable(drive_enable),
		.brake_engage(brake_engage), .power_applied(power_applied), .amp_ready(amp_ready),
		.stop_active(stop_active), .stop_kind(stop_kind), .stop_smooth(stop_smooth),
		.halt_active(halt_active), .halt_kind(halt_kind), .mode_active(mode_active),
		.drive_state(drive_state));
	ddc_chk_sva u_ddc_chk_sva (.sys_clk(sys_clk), .arst_n(arst_n), .req(u_ddc_if.req),
		.wr(u_ddc_if.wr), .idx(u_ddc_if.idx), .wdata(u_ddc_if.wdata), .ack(u_ddc_if.ack),
		.abort(u_ddc_if.abort), .rdata(u_ddc_if.rdata));

	// Clock at 20 MHz
	always #25 sys_clk = ~sys_clk;

	// Inputs move 5 ns after the rising edge, clear of sampling
	task automatic step();
		@(posedge sys_clk);
		#5;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		chk({15'h0000, g}, {15'h0000, e});
	endtask
	// One request through the master; waits a bounded time for done
	task automatic xfer(input logic raw, input logic w, input logic [15:0] i,
		input logic [15:0] d, input ddc_dcmd_t c);
		int n = 0;
		{acc_write, acc_index, acc_data} = {w, i, d};
		dcmd = c;
		{acc_valid, dcmd_valid} = {raw, !raw};
		step();
		{acc_valid, dcmd_valid} = 2'b00;
		chk1(acc_ready, 1'b0);
		while (done !== 1'b1 && n < 20) begin
			step();
			n++;
		end
		chk1(done, 1'b1);
	endtask
	task automatic acc(input logic w, input logic [15:0] i, input logic [15:0] d);
		xfer(1'b1, w, i, d, DC_SHUTDOWN);
	endtask
	task automatic cmd(input ddc_dcmd_t c);
		xfer(1'b0, 1'b0, 16'h0000, 16'h0000, c);
	endtask
	// State moves can trail the command or event by a cycle; bounded wait
	task automatic wait_st(input ddc_state_t s);
		int n = 0;
		while (drive_state !== s && n < 40) begin
			step();
			n++;
		end
		chk(16'(drive_state), 16'(s));
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Main sequence: reset, table of accesses, modes, then the state walk
	initial begin
		{acc_valid, acc_write, dcmd_valid, init_done, fault_event, stop_done} = '0;
		{acc_index, acc_data} = '0;
		dcmd = DC_SHUTDOWN;
		{safe_torque_off_input, power_stage_enable_input, pp_start_req} = 3'b111;
		arst_n = 1'b0;
		repeat (16) @(posedge sys_clk);
		#5;
		chk(16'(drive_state), 16'(ST_NOT_READY));
		chk1(brake_engage, 1'b1);
		chk1(drive_enable, 1'b0);
		arst_n = 1'b1;
		step();
		foreach (rows[k]) begin
			acc(rows[k].w, rows[k].i, rows[k].d);
			chk1(done_abort, rows[k].ab);
			chk(done_data, rows[k].rd);
		end
		foreach (modes[k]) begin
			acc(1'b1, IDX_MODE_SEL, {8'h00, modes[k]});
			chk1(done_abort, 1'b0);
			acc(1'b0, IDX_MODE_SHOW, 16'h0000);
			chk(done_data, {8'h00, modes[k]});
			chk({8'h00, mode_active}, {8'h00, modes[k]});
		end
		init_done = 1'b1;
		wait_st(ST_SW_ON_DIS);
		chk1(pp_start_grant, 1'b0);
		cmd(DC_EN_OP);
		repeat (8) step();
		wait_st(ST_SW_ON_DIS);
		cmd(DC_SHUTDOWN);
		wait_st(ST_READY);
		acc(1'b0, IDX_STATE_WORD, 16'h0000);
		chk(done_data, SW_READY | SW_VOLTAGE);
		chk1(power_applied, 1'b1);
		cmd(DC_SWITCH_ON);
		wait_st(ST_SWITCHED_ON);
		chk1(amp_ready, 1'b1);
		chk1(drive_enable, 1'b0);
		cmd(DC_EN_OP);
		wait_st(ST_OP_EN);
		chk1(drive_enable, 1'b1);
		chk1(pp_start_grant, 1'b1);
		// Stay variant of quick stop: ramp ends but state is held
		cmd(DC_QSTOP);
		wait_st(ST_QSTOP);
		step();
		chk1(stop_active, 1'b1);
		chk(16'(stop_kind), 16'(STOP_QS_RAMP));
		chk1(stop_smooth, 1'b1);
		chk1(pp_start_grant, 1'b0);
		stop_done = 1'b1;
		repeat (8) step();
		wait_st(ST_QSTOP);
		cmd(DC_EN_OP);
		wait_st(ST_OP_EN);
		cmd(DC_DIS_OP);
		wait_st(ST_SWITCHED_ON);
		cmd(DC_EN_OP);
		wait_st(ST_OP_EN);
		cmd(DC_SHUTDOWN);
		wait_st(ST_READY);
		chk(16'(stop_kind), 16'(STOP_QS_RAMP));
		cmd(DC_SWITCH_ON);
		cmd(DC_EN_OP);
		wait_st(ST_OP_EN);
		acc(1'b1, IDX_CMD_WORD, 16'h010f);
		step();
		chk1(halt_active, 1'b1);
		chk(16'(halt_kind), 16'(STOP_SLOW_RAMP));
		// Internal error while enabled: reaction ramp, then fault
		stop_done = 1'b0;
		fault_event = 1'b1;
		wait_st(ST_FAULT_REACT);
		step();
		chk(16'(stop_kind), 16'(STOP_VOLT_LIM));
		chk1(stop_smooth, 1'b0);
		stop_done = 1'b1;
		wait_st(ST_FAULT);
		chk1(drive_enable, 1'b0);
		fault_event = 1'b0;
		cmd(DC_FAULT_RESET);
		wait_st(ST_SW_ON_DIS);
		cmd(DC_SHUTDOWN);
		wait_st(ST_READY);
		cmd(DC_DVOLT);
		wait_st(ST_SW_ON_DIS);
		power_stage_enable_input = 1'b0;
		cmd(DC_SHUTDOWN);
		repeat (8) step();
		wait_st(ST_SW_ON_DIS);
		close_out();
	end

	// Watchdog well beyond the expected run of about 220 cycles
	initial begin
		#400000;
		n_errors++;
		close_out();
	end
endmodule
`default_nettype wire
